// [src/rsc_pkg.sv]
package rsc_pkg;

   // Register byte offsets
   localparam logic [7:0] RSC_OFF_STATUS = 8'h00;
   localparam logic [7:0] RSC_OFF_STRAPS = 8'h04;
   localparam logic [7:0] RSC_OFF_CTRL = 8'h08;
   localparam logic [7:0] RSC_OFF_IRQ_STAT = 8'h0c;
   localparam logic [7:0] RSC_OFF_IRQ_CLR = 8'h10;
   localparam logic [7:0] RSC_OFF_IRQ_EN = 8'h14;

   // Source bit positions in status and interrupt registers
   localparam int RSC_SRC_POR = 0;
   localparam int RSC_SRC_HARD_EXT = 1;
   localparam int RSC_SRC_WDOG = 2;
   localparam int RSC_SRC_BMON = 3;
   localparam int RSC_SRC_TAP = 4;
   localparam int RSC_NSRC = 5;

   // Control register fields
   localparam int RSC_CTRL_WDOG_EN = 0;
   localparam int RSC_CTRL_BMON_EN = 1;
   localparam logic [31:0] RSC_CTRL_RESET = 32'h0000_0001;

   // Timing in input clock cycles
   localparam int RSC_POR_MIN_CYC = 16;
   localparam int RSC_HARD_REL_CYC = 521;
   localparam int RSC_HARD_HOLD_CYC = 521;
   localparam int RSC_CORE_HOLD_CYC = 16;
   localparam int RSC_CNT_W = 10;

   typedef struct packed {
      logic [1:0] boot_source_select;
      logic watchdog_enable_strap;
      logic host_byte_width_strap;
      logic host_strobe_polarity_strap;
   } rsc_straps_t;

   // Reset outputs toward the rest of the chip
   typedef struct packed {
      logic system_pll;
      logic timer_regs;
      logic stop_control_reg;
      logic halt_handshake;
      logic ext_core;
      logic periph;
   } rsc_resets_t;

   typedef enum logic [3:0] {
      RSC_ST_IDLE = 4'b0001,
      RSC_ST_POR = 4'b0010,
      RSC_ST_HARD = 4'b0100,
      RSC_ST_SOFT = 4'b1000
   } rsc_state_t;

endpackage

// [src/rsc_reset_source_controller.sv]
// The APB register port and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
module rsc_reset_source_controller
(
   input wire logic clk,
   input wire logic rst,
   input wire logic power_on_reset_n,
   input wire logic hard_reset_n_in,
   output logic hard_reset_n_out,
   output logic hard_reset_n_oe,
   input wire logic watchdog_expired,
   input wire logic bus_monitor_expired,
   input wire logic tap_boundary_cmd,
   input wire logic [1:0] boot_source_select,
   input wire logic watchdog_enable_strap,
   input wire logic host_byte_width_strap,
   input wire logic host_strobe_polarity_strap,
   output rsc_pkg::rsc_straps_t straps,
   output rsc_pkg::rsc_resets_t resets,
   output logic soft_reset_internal,
   output logic irq,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);

   logic [2:0] por_sync_q;
   logic [2:0] hpin_sync_q;
   logic [2:0] tap_sync_q;
   logic [1:0] strap_sync1_q;
   logic [1:0] strap_sync2_q;
   logic [4:0] strap_raw_q;
   logic [4:0] strap_s_q;
   logic por_n_s;
   logic hpin_n_s;
   logic por_rise;
   logic tap_rise;
   logic wdog_ev;
   logic bmon_ev;
   logic hard_ext_ev;
   rsc_pkg::rsc_state_t state_q;
   logic [rsc_pkg::RSC_CNT_W-1:0] cnt_q;
   logic [rsc_pkg::RSC_NSRC-1:0] src_q;
   logic [rsc_pkg::RSC_NSRC-1:0] pend_q;
   logic [rsc_pkg::RSC_NSRC-1:0] ev;
   logic [rsc_pkg::RSC_NSRC-1:0] irq_stat_q;
   logic [rsc_pkg::RSC_NSRC-1:0] irq_en_q;
   logic [31:0] ctrl_q;
   logic wr_en;
   logic pll_rst_q;
   logic core_rst_q;
   logic drive_pin_q;
   logic soft_q;
   logic [1:0] drv_echo_q;

   // Two-stage synchronisers; third stage only for edge detection
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         por_sync_q <= 3'h0;
         hpin_sync_q <= 3'h7;
         tap_sync_q <= 3'h0;
      end
      else
      begin
         por_sync_q <= {por_sync_q[1:0], power_on_reset_n};
         hpin_sync_q <= {hpin_sync_q[1:0], hard_reset_n_in};
         tap_sync_q <= {tap_sync_q[1:0], tap_boundary_cmd};
      end
   end

   // Strap pins also pass two flops before capture
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         strap_raw_q <= 5'h00;
         strap_s_q <= 5'h00;
      end
      else
      begin
         strap_raw_q <= {boot_source_select, watchdog_enable_strap,
                         host_byte_width_strap, host_strobe_polarity_strap};
         strap_s_q <= strap_raw_q;
      end
   end

   assign por_n_s = por_sync_q[1];
   assign hpin_n_s = hpin_sync_q[1];
   assign por_rise = por_sync_q[1] & ~por_sync_q[2];
   assign tap_rise = tap_sync_q[1] & ~tap_sync_q[2];

   assign wdog_ev = watchdog_expired & ctrl_q[rsc_pkg::RSC_CTRL_WDOG_EN];
   assign bmon_ev = bus_monitor_expired & ctrl_q[rsc_pkg::RSC_CTRL_BMON_EN];
   // pin pulled low by others; our own drive and its synchroniser echo are masked
   assign hard_ext_ev = ~hpin_n_s & ~drive_pin_q & ~(|drv_echo_q);
   assign ev = {tap_rise, bmon_ev, wdog_ev, hard_ext_ev, ~por_n_s};

   // Sequencer: power-on beats hard beats soft
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         state_q <= rsc_pkg::RSC_ST_POR;
         cnt_q <= '0;
         pend_q <= '0;
         src_q <= 5'h01;
      end
      else if (!por_n_s)
      begin
         state_q <= rsc_pkg::RSC_ST_POR;
         cnt_q <= '0;
         pend_q <= 5'h01;
      end
      else
      begin
         unique case (state_q)
            rsc_pkg::RSC_ST_IDLE:
            begin
               cnt_q <= '0;
               pend_q <= ev;
               if (hard_ext_ev || wdog_ev || bmon_ev)
                  state_q <= rsc_pkg::RSC_ST_HARD;
               else if (tap_rise)
                  state_q <= rsc_pkg::RSC_ST_SOFT;
            end
            rsc_pkg::RSC_ST_POR:
            begin
               // pin held a fixed count past power-on release
               // Four cycles go to the input synchroniser, this state and the pin flop
               if (cnt_q == rsc_pkg::RSC_CNT_W'(rsc_pkg::RSC_HARD_REL_CYC - 4))
               begin
                  state_q <= rsc_pkg::RSC_ST_IDLE;
                  src_q <= pend_q | ev;
               end
               else
                  cnt_q <= cnt_q + 1'b1;
            end
            rsc_pkg::RSC_ST_HARD:
            begin
               // Pin is let go at the end of the hold; the line must then read high
               pend_q <= pend_q | ev;
               if (cnt_q == rsc_pkg::RSC_CNT_W'(rsc_pkg::RSC_HARD_HOLD_CYC - 1) && hpin_n_s)
               begin
                  state_q <= rsc_pkg::RSC_ST_IDLE;
                  src_q <= pend_q;
               end
               else if (cnt_q != rsc_pkg::RSC_CNT_W'(rsc_pkg::RSC_HARD_HOLD_CYC - 1))
                  cnt_q <= cnt_q + 1'b1;
            end
            rsc_pkg::RSC_ST_SOFT:
            begin
               pend_q <= pend_q | ev;
               if (hard_ext_ev || wdog_ev || bmon_ev)
               begin
                  state_q <= rsc_pkg::RSC_ST_HARD;
                  cnt_q <= '0;
               end
               else if (cnt_q == rsc_pkg::RSC_CNT_W'(rsc_pkg::RSC_CORE_HOLD_CYC - 1))
               begin
                  state_q <= rsc_pkg::RSC_ST_IDLE;
                  src_q <= pend_q;
               end
               else
                  cnt_q <= cnt_q + 1'b1;
            end
            default:
               state_q <= rsc_pkg::RSC_ST_POR;
         endcase
      end
   end

   // straps caught once, at power-on release
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         straps <= '0;
      // hard and soft flows never reach here
      else if (por_rise)
         straps <= rsc_pkg::rsc_straps_t'(strap_s_q);
   end

   // Reset outputs registered per flow
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         pll_rst_q <= 1'b1;
         core_rst_q <= 1'b1;
         drive_pin_q <= 1'b1;
         soft_q <= 1'b0;
      end
      else
      begin
         // PLL only follows the power-on input
         pll_rst_q <= ~por_n_s;
         // every flow resets core, timers, peripherals
         core_rst_q <= (state_q != rsc_pkg::RSC_ST_IDLE);
         // soft flow leaves the pin alone; hard flow lets go after its hold
         drive_pin_q <= (state_q == rsc_pkg::RSC_ST_POR) ||
                        ((state_q == rsc_pkg::RSC_ST_HARD) &&
                         (cnt_q != rsc_pkg::RSC_CNT_W'(rsc_pkg::RSC_HARD_HOLD_CYC - 1)));
         soft_q <= (state_q == rsc_pkg::RSC_ST_SOFT);
      end
   end

   // Our own drive as it comes back through the pin synchroniser;
   // without it the self-made low would look like an outside hard request
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         drv_echo_q <= 2'h3;
      else
         drv_echo_q <= {drv_echo_q[0], drive_pin_q};
   end

   // open drain: output data always low, only enable toggles
   assign hard_reset_n_out = 1'b0;
   assign hard_reset_n_oe = drive_pin_q;
   assign soft_reset_internal = soft_q;

   // stop control and halt handshake cleared in every flow
   always_comb
   begin
      resets.system_pll = pll_rst_q;
      resets.timer_regs = core_rst_q;
      resets.stop_control_reg = core_rst_q;
      resets.halt_handshake = core_rst_q;
      resets.ext_core = core_rst_q;
      resets.periph = core_rst_q;
   end

   assign wr_en = psel & penable & pwrite;

   // Control register; watchdog enable follows the strap after power-on
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         ctrl_q <= rsc_pkg::RSC_CTRL_RESET;
      else if (por_rise)
         ctrl_q[rsc_pkg::RSC_CTRL_WDOG_EN] <= strap_s_q[2];
      else if (wr_en && paddr == rsc_pkg::RSC_OFF_CTRL)
         ctrl_q <= {30'h0, pwdata[1:0]};
   end

   // Sticky event bits; a new event wins over a clear
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         irq_stat_q <= '0;
         irq_en_q <= '0;
      end
      else
      begin
         if (wr_en && paddr == rsc_pkg::RSC_OFF_IRQ_CLR)
            irq_stat_q <= (irq_stat_q & ~pwdata[4:0]) | ev;
         else
            irq_stat_q <= irq_stat_q | ev;
         if (wr_en && paddr == rsc_pkg::RSC_OFF_IRQ_EN)
            irq_en_q <= pwdata[4:0];
      end
   end

   assign irq = |(irq_stat_q & irq_en_q);

   // APB: zero wait states, error on unmapped address
   assign pready = 1'b1;

   always_comb
   begin
      prdata = 32'h0;
      pslverr = 1'b0;
      unique case (paddr)
         rsc_pkg::RSC_OFF_STATUS: prdata = {27'h0, src_q};
         rsc_pkg::RSC_OFF_STRAPS: prdata = {27'h0, straps};
         rsc_pkg::RSC_OFF_CTRL: prdata = ctrl_q;
         rsc_pkg::RSC_OFF_IRQ_STAT: prdata = {27'h0, irq_stat_q};
         rsc_pkg::RSC_OFF_IRQ_CLR: prdata = 32'h0;
         rsc_pkg::RSC_OFF_IRQ_EN: prdata = {27'h0, irq_en_q};
         default: pslverr = psel & penable;
      endcase
   end

endmodule

// [testbench/rsc_reset_source_controller_sva.sv]
`timescale 1ns/10ps
module rsc_sva
(
   input wire logic clk,
   input wire logic rst,
   input wire logic power_on_reset_n,
   input wire logic hard_reset_n_in,
   input wire logic hard_reset_n_out,
   input wire logic hard_reset_n_oe,
   input rsc_pkg::rsc_straps_t straps,
   input rsc_pkg::rsc_resets_t resets,
   input wire logic soft_reset_internal,
   input wire logic irq
);
   logic [9:0] cnt_q;
   logic [9:0] cnt_d;
   default clocking @(posedge clk);
   endclocking
   default disable iff (rst);
   // Cycles since power-on input rose; saturates so later resets read as far away
   assign cnt_d = !power_on_reset_n ? 10'h0 : cnt_q + {9'h0, cnt_q != 10'h3ff};
   always_ff @(posedge clk or posedge rst)
      if (rst)
         cnt_q <= 10'h0;
      else
         cnt_q <= cnt_d;
   property p_por_all;
      // Synchroniser and output flop put three cycles between pin and PLL reset; pin enable and core reset add the state flop for four
      !power_on_reset_n |-> ##3 (resets.system_pll && hard_reset_n_oe && resets.ext_core);
   endproperty
   a_por_all: assert property (p_por_all) else $error("power-on flow incomplete");
   property p_straps;
      !$stable(straps) |-> cnt_q inside {[10'd1:10'd6]};
   endproperty
   a_straps: assert property (p_straps) else $error("straps changed late");
   property p_od;
      hard_reset_n_out == 1'b0;
   endproperty
   a_od: assert property (p_od) else $error("pin driven high");
   property p_hard;
      $fell(hard_reset_n_in) |-> ##[1:5] (hard_reset_n_oe && resets.ext_core);
   endproperty
   a_hard: assert property (p_hard) else $error("pin low not followed");
   property p_pll;
      (soft_reset_internal || hard_reset_n_oe) && cnt_q == 10'h3ff |-> !resets.system_pll;
   endproperty
   a_pll: assert property (p_pll) else $error("pll reset outside power-on");
   property p_soft_core;
      soft_reset_internal |-> resets.timer_regs && resets.ext_core && resets.periph;
   endproperty
   a_soft_core: assert property (p_soft_core) else $error("soft core reset missing");
   property p_soft_clk;
      soft_reset_internal |-> resets.stop_control_reg && resets.halt_handshake;
   endproperty
   a_soft_clk: assert property (p_soft_clk) else $error("soft stop reset missing");
   property p_rel;
      $fell(hard_reset_n_oe) && cnt_q != 10'h3ff |-> cnt_q inside {[10'd521:10'd528]};
   endproperty
   a_rel: assert property (p_rel) else $error("pin release time wrong");
   property p_soft_pin;
      soft_reset_internal |-> !hard_reset_n_oe;
   endproperty
   a_soft_pin: assert property (p_soft_pin) else $error("soft flow drove pin");
   c_soft: cover property ($rose(soft_reset_internal));
   c_rel: cover property ($fell(hard_reset_n_oe));
   c_irq: cover property ($rose(irq));
endmodule
bind rsc_reset_source_controller rsc_sva u_rsc_sva (.*);

// [testbench/rsc_board_model.sv]
`timescale 1ns/10ps
// Board side: power-on supervisor and the pulled-up hard reset pin
module rsc_board_model
(
   input wire logic clk,
   input wire logic pull_hard,
   input wire logic hard_reset_n_oe,
   input wire logic hard_reset_n_out,
   output logic power_on_reset_n = 1'b0,
   output logic hard_reset_n_in
);
   int hold_q = 24;
   always @(posedge clk)
   begin
      if (hold_q > 0)
         hold_q <= hold_q - 1;
      power_on_reset_n <= (hold_q == 0);
   end
   // Pull-up wins unless someone sinks the line
   assign hard_reset_n_in = !(pull_hard || (hard_reset_n_oe && !hard_reset_n_out));
endmodule

// [testbench/rsc_reset_source_controller_tb_top.sv]
`timescale 1ns/10ps
module rsc_reset_source_controller_tb_top;
   logic clk = 0, rst = 1, pull_hard = 0, psel = 0, penable = 0, pwrite = 0, er;
   logic watchdog_expired = 0, bus_monitor_expired = 0, tap_boundary_cmd = 0;
   logic [1:0] boot_source_select = 2'h2;
   logic watchdog_enable_strap = 1, host_byte_width_strap = 0, host_strobe_polarity_strap = 1;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic power_on_reset_n, hard_reset_n_in, hard_reset_n_out, hard_reset_n_oe;
   logic soft_reset_internal, irq, pready, pslverr;
   rsc_pkg::rsc_straps_t straps;
   rsc_pkg::rsc_resets_t resets;
   int num_errors = 0, n_compared = 0, n;
   rsc_reset_source_controller u_rsc_reset_source_controller (.*);
   rsc_board_model u_rsc_board_model (.*);
   // Free-running 50 MHz clock
   initial
      forever #10 clk = ~clk;
   task chk(input string s, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e)
      begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", s, e, g);
      end
   endtask
   // Request held until pready is seen high at an edge
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Bounded wait for the pin enable to reach a level; idle also needs core reset gone
   task wt(input logic v);
      n = 0;
      while ((hard_reset_n_oe !== v || (!v && resets.ext_core !== 1'b0)) && n < 800)
      begin
         @(negedge clk);
         n++;
      end
      if (n == 800)
      begin
         num_errors++;
         $display("[FAIL] pin enable expected %h seen %h", v, hard_reset_n_oe);
      end
      @(posedge clk);
   endtask
   task results;
      $display("errors %0d compared %0d", num_errors, n_compared);
      if (num_errors == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial
   begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      @(posedge power_on_reset_n);
      wt(1'b0);
      chk("release", 1, n >= 521 && n <= 528);
      chk("straps", 32'h15, {27'h0, straps});
      apb(0, rsc_pkg::RSC_OFF_STRAPS, 0);
      chk("strap reg", 32'h15, {27'h0, rd[4:0]});
      apb(0, rsc_pkg::RSC_OFF_STATUS, 0);
      chk("por status", 1, rd[rsc_pkg::RSC_SRC_POR]);
      $display("power-on test done");
      boot_source_select <= 2'h1;
      pull_hard <= 1'b1;
      wt(1'b1);
      chk("hard pll", 0, resets.system_pll);
      chk("hard core", 1, resets.ext_core);
      pull_hard <= 1'b0;
      wt(1'b0);
      chk("kept straps", 32'h15, {27'h0, straps});
      apb(0, rsc_pkg::RSC_OFF_STATUS, 0);
      chk("ext status", 1, rd[rsc_pkg::RSC_SRC_HARD_EXT]);
      $display("pin test done");
      for (int i = 0; i < 2; i++)
      begin
         apb(1, rsc_pkg::RSC_OFF_CTRL, 32'h3);
         apb(0, rsc_pkg::RSC_OFF_CTRL, 0);
         chk("ctrl", 32'h3, rd);
         watchdog_expired <= (i == 0);
         bus_monitor_expired <= (i == 1);
         @(posedge clk);
         watchdog_expired <= 1'b0;
         bus_monitor_expired <= 1'b0;
         wt(1'b1);
         chk("int hard", 1, hard_reset_n_oe);
         wt(1'b0);
         apb(0, rsc_pkg::RSC_OFF_STATUS, 0);
         chk("int status", 1, rd[rsc_pkg::RSC_SRC_WDOG + i]);
      end
      $display("internal test done");
      apb(1, rsc_pkg::RSC_OFF_IRQ_CLR, 32'h1f);
      apb(1, rsc_pkg::RSC_OFF_IRQ_EN, 32'h10);
      tap_boundary_cmd <= 1'b1;
      repeat (6) @(posedge clk);
      chk("soft", 1, soft_reset_internal);
      chk("soft pin", 0, hard_reset_n_oe);
      chk("soft core", 1, resets.ext_core);
      chk("soft stop", 1, resets.stop_control_reg);
      tap_boundary_cmd <= 1'b0;
      repeat (30) @(posedge clk);
      apb(0, rsc_pkg::RSC_OFF_STATUS, 0);
      chk("tap status", 1, rd[rsc_pkg::RSC_SRC_TAP]);
      @(negedge clk);
      chk("irq on", 1, irq);
      apb(1, rsc_pkg::RSC_OFF_IRQ_EN, 32'h0);
      @(negedge clk);
      chk("irq masked", 0, irq);
      apb(1, rsc_pkg::RSC_OFF_IRQ_EN, 32'h10);
      apb(1, rsc_pkg::RSC_OFF_IRQ_CLR, 32'h1f);
      @(negedge clk);
      chk("irq cleared", 0, irq);
      apb(0, 8'h40, 0);
      chk("unmapped", 1, er);
      $display("soft and irq test done");
      results();
   end
   // Whole run is near 2200 cycles
   initial
   begin
      #200000;
      num_errors++;
      results();
   end
endmodule
